// ===== sss_bridge.sv
`timescale 1ns/1ns
// Comparators do not look at switch state, so a fault can be forced on any switch.
module sss_bridge (
  input  wire logic [7:0] trip,
  output logic      [7:0] sw_overcurrent
);
  assign sw_overcurrent = trip;
endmodule

// ===== sss_chop_timer.sv
`timescale 1ns/1ns
// Free-running chopping period timer; pulses once at the start of each period.
module sss_chop_timer #(
  parameter int PERIOD = sss_pkg::CHOP_CYCLES
) (
  input  wire logic core_clk,
  input  wire logic rst_n,
  output logic      period_start
);

  initial begin
    if (PERIOD < 2) $error("sss_chop_timer: PERIOD must be at least 2");
  end

  localparam int CW = $clog2(PERIOD);

  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic          next_period_start;

  always_comb begin
    next_period_start = 1'b0;
    next_count        = count - 1'b1;
    if (count == '0) begin
      next_count        = CW'(PERIOD - 1);
      next_period_start = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      count        <= '0;
      period_start <= 1'b0;
    end else begin
      count        <= next_count;
      period_start <= next_period_start;
    end
  end

endmodule

// ===== sss_pkg.sv
package sss_pkg;

  // Timing at the 50 MHz core clock.
  localparam int CLK_HZ       = 50_000_000;
  localparam int CHOP_HZ      = 40_000;
  localparam int CHOP_CYCLES  = CLK_HZ / CHOP_HZ;

  // Step positions per electrical cycle and counter width.
  localparam int STEP_POS     = 8;
  localparam int STEP_W       = 3;
  localparam logic [2:0] STEP_INIT = 3'h0;
  localparam logic [2:0] PHASE_B_LAG = 3'h2;

  // Current levels in percent of full scale.
  localparam logic [6:0] LVL_FULL = 7'h64;
  localparam logic [6:0] LVL_MID  = 7'h47;
  localparam logic [6:0] LVL_ZERO = 7'h00;

  // Output switch count and positions inside one phase bridge.
  localparam int NUM_SW  = 8;
  localparam int SW_HI1  = 0;
  localparam int SW_LO1  = 1;
  localparam int SW_HI2  = 2;
  localparam int SW_LO2  = 3;

  typedef struct packed {
    logic       neg;
    logic [6:0] level;
  } sss_phase_t;

  typedef struct packed {
    sss_phase_t a;
    sss_phase_t b;
  } sss_current_t;

  localparam sss_current_t CUR_INIT = '{a: '{neg: 1'b0, level: 7'h64},
                                        b: '{neg: 1'b0, level: 7'h00}};

endpackage

// ===== sss_step_sequencer.sv
`timescale 1ns/1ns
// What this block and its controller do
// R1: Controller keeps enable low during power changes.
// R2: Each step clock rise advances step counter while reset is high.
// R3: Enable low: outputs off; high: windings driven.
// R4: Reset low forces phase A full, B zero.
// R5: Enable low, reset low: off, initial mode.
// R6: Enable low, reset high: off, counter advances.
// R7: Enable and reset high: drive counter level.
// R8: Current starts at next chopping period start.
// R9: Controller raises enable then releases reset.
// R10: Any of eight switches over-current drives fault low.
// R11: Over-current turns every output switch off.
// R12: Controller respects maximum step clock frequency.
// R13: Counter changes only on step edges, reset.
module sss_step_sequencer #(
  parameter int CHOP_CYCLES = sss_pkg::CHOP_CYCLES
) (
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  input  wire logic                 step_clk,
  input  wire logic                 out_enable,
  input  wire logic                 init_n,
  input  wire logic [7:0]           sw_overcurrent,
  output sss_pkg::sss_current_t     cur_set,
  output logic      [7:0]           sw_on,
  output logic                      drive_active,
  output logic                      fault_n
);

  initial begin
    if (sss_pkg::STEP_POS != (1 << sss_pkg::STEP_W))
      $error("sss_step_sequencer: STEP_POS must equal 2**STEP_W");
  end

  logic chop_start;

  sss_chop_timer #(
    .PERIOD (CHOP_CYCLES)
  ) u_chop (
    .core_clk     (core_clk),
    .rst_n        (rst_n),
    .period_start (chop_start)
  );

  // Level table for one electrical cycle; phase B reads it lagging by two positions.
  function automatic sss_pkg::sss_phase_t level_of(input logic [2:0] pos);
    sss_pkg::sss_phase_t p;
    p.neg = pos[2];
    case (pos[1:0])
      2'h0:    p.level = sss_pkg::LVL_FULL;
      2'h1:    p.level = sss_pkg::LVL_MID;
      2'h2:    p.level = sss_pkg::LVL_ZERO;
      default: p.level = sss_pkg::LVL_MID;
    endcase
    if (pos[1:0] == 2'h3) p.neg = ~pos[2];
    // A zero level carries no sign, so both zero positions match the initial setting.
    if (pos[1:0] == 2'h2) p.neg = 1'b0;
    return p;
  endfunction

  logic                        step_prev;
  logic [sss_pkg::STEP_W-1:0]  step_pos;
  logic                        oc_latched;
  logic [sss_pkg::STEP_W-1:0]  next_step_pos;
  logic                        next_drive_active;
  logic                        next_oc_latched;
  sss_pkg::sss_current_t       next_cur_set;
  logic [7:0]                  next_sw_on;

  always_comb begin
    next_step_pos = step_pos;
    if (!init_n) begin
      next_step_pos = sss_pkg::STEP_INIT;                      // [R4] [R5] [R13]
    end else if (step_clk && !step_prev) begin
      next_step_pos = step_pos + 1'b1;                         // [R2] [R6] [R13]
    end
  end

  always_comb begin
    next_cur_set.a = level_of(next_step_pos);                  // [R7]
    next_cur_set.b = level_of(next_step_pos - sss_pkg::PHASE_B_LAG);
    if (!init_n) next_cur_set = sss_pkg::CUR_INIT;             // [R4]
  end

  always_comb begin
    // Fault clears only while the outputs are disabled, so a short is never re-driven
    // without the controller first taking enable low.
    next_oc_latched = oc_latched;
    if (!out_enable) next_oc_latched = 1'b0;
    if (out_enable && drive_active && (|sw_overcurrent))
      next_oc_latched = 1'b1;                                  // [R10]
    next_drive_active = drive_active;
    if (!out_enable) begin
      next_drive_active = 1'b0;                                // [R3]
    end else if (chop_start) begin
      next_drive_active = 1'b1;                                // [R8]
    end
  end

  always_comb begin
    next_sw_on = 8'h00;
    if (next_drive_active && !next_oc_latched) begin           // [R3] [R11]
      if (next_cur_set.a.level != sss_pkg::LVL_ZERO) begin
        next_sw_on[sss_pkg::SW_HI1] = !next_cur_set.a.neg;
        next_sw_on[sss_pkg::SW_LO2] = !next_cur_set.a.neg;
        next_sw_on[sss_pkg::SW_HI2] = next_cur_set.a.neg;
        next_sw_on[sss_pkg::SW_LO1] = next_cur_set.a.neg;
      end
      if (next_cur_set.b.level != sss_pkg::LVL_ZERO) begin
        next_sw_on[4 + sss_pkg::SW_HI1] = !next_cur_set.b.neg;
        next_sw_on[4 + sss_pkg::SW_LO2] = !next_cur_set.b.neg;
        next_sw_on[4 + sss_pkg::SW_HI2] = next_cur_set.b.neg;
        next_sw_on[4 + sss_pkg::SW_LO1] = next_cur_set.b.neg;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      step_prev    <= 1'b0;
      step_pos     <= sss_pkg::STEP_INIT;
      oc_latched   <= 1'b0;
      drive_active <= 1'b0;
      cur_set      <= sss_pkg::CUR_INIT;
      sw_on        <= 8'h00;
      fault_n      <= 1'b1;
    end else begin
      step_prev    <= step_clk;
      step_pos     <= next_step_pos;
      oc_latched   <= next_oc_latched;
      drive_active <= next_drive_active;
      cur_set      <= next_cur_set;
      sw_on        <= next_sw_on;
      fault_n      <= !next_oc_latched;                        // [R10]
    end
  end

endmodule

// ===== sss_sva.sv
`timescale 1ns/1ns
module sss_sva #(
  parameter int CHOP_CYCLES = sss_pkg::CHOP_CYCLES
) (
  input wire logic                  core_clk,
  input wire logic                  rst_n,
  input wire logic                  step_clk,
  input wire logic                  out_enable,
  input wire logic                  init_n,
  input wire logic [7:0]            sw_overcurrent,
  input wire sss_pkg::sss_current_t cur_set,
  input wire logic [7:0]            sw_on,
  input wire logic                  drive_active,
  input wire logic                  fault_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_step; $rose(step_clk) && init_n; endsequence
  sequence s_en_held; $rose(out_enable) ##1 (out_enable && fault_n)[*8]; endsequence
  a_step_moves: assert property (s_step |=> cur_set != $past(cur_set))
    else $error("step lost");
  a_hold_still: assert property (init_n && !$rose(step_clk) |=> $stable(cur_set))
    else $error("setting drifted");
  a_init_force: assert property (!init_n |=> cur_set == sss_pkg::CUR_INIT)
    else $error("not initial");
  a_off_disabled: assert property (!out_enable |=> sw_on == 8'h00)
    else $error("driven while off");
  a_drive_start: assert property (s_en_held |=> drive_active || (CHOP_CYCLES > 8))
    else $error("drive late");
  a_sw_drive: assert property (sw_on != 8'h00 |-> drive_active && fault_n)
    else $error("sw without drive");
  a_fault_trip: assert property (out_enable && drive_active && |sw_overcurrent |=> !fault_n)
    else $error("no fault");
  a_fault_off: assert property (!fault_n |-> sw_on == 8'h00)
    else $error("sw on in fault");
endmodule
bind sss_step_sequencer sss_sva #(.CHOP_CYCLES(CHOP_CYCLES)) sva_u (.core_clk(core_clk),
  .rst_n(rst_n), .step_clk(step_clk), .out_enable(out_enable), .init_n(init_n),
  .sw_overcurrent(sw_overcurrent), .cur_set(cur_set), .sw_on(sw_on),
  .drive_active(drive_active), .fault_n(fault_n));

// ===== tb.sv
`timescale 1ns/1ns
`define CHK(n,e,g) begin check_count++; if ((g) !== (e)) begin mismatches++; $display("BAD %s exp %h got %h", n, e, g); end end
module tb;
  logic                  core_clk = 1'b0;
  logic                  rst_n = 1'b0;
  logic                  step_clk = 1'b0;
  logic                  out_enable = 1'b0;
  logic                  init_n = 1'b0;
  logic [7:0]            trip = 8'h00;
  logic [7:0]            sw_overcurrent;
  sss_pkg::sss_current_t cur_set;
  logic [7:0]            sw_on;
  logic                  drive_active;
  logic                  fault_n;
  int                    mismatches = 0;
  int                    check_count = 0;
  logic [6:0]            lvl [8] = '{7'h64, 7'h47, 7'h00, 7'h47, 7'h64, 7'h47, 7'h00, 7'h47};
  sss_step_sequencer #(.CHOP_CYCLES(8)) dut_u (.core_clk(core_clk), .rst_n(rst_n),
    .step_clk(step_clk), .out_enable(out_enable), .init_n(init_n),
    .sw_overcurrent(sw_overcurrent), .cur_set(cur_set), .sw_on(sw_on),
    .drive_active(drive_active), .fault_n(fault_n));
  sss_bridge bridge_u (.trip(trip), .sw_overcurrent(sw_overcurrent));
  function automatic sss_pkg::sss_current_t exp_cur(input logic [2:0] p);
    logic [2:0] q;
    q = p - 3'h2;
    return '{a: '{neg: p inside {[3'h3:3'h5]}, level: lvl[p]},
             b: '{neg: q inside {[3'h3:3'h5]}, level: lvl[q]}};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask
  // Low for a full cycle between pulses gives one rise per two core cycles, the fastest rate the edge detector can see.
  task automatic step;
    step_clk = 1'b1;
    tick(1);
    step_clk = 1'b0;
    tick(1);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    forever #10 core_clk = ~core_clk;
  end
  initial begin
    #200000;
    mismatches++;
    test_done;
  end
  initial begin
    tick(3);
    rst_n = 1'b1;
    tick(1);
    `CHK("reset", sss_pkg::CUR_INIT, cur_set)
    `CHK("fault", 1'b1, fault_n)
    init_n = 1'b1;
    tick(1);
    for (int i = 1; i <= 9; i++) begin
      step;
      `CHK("pos", exp_cur(i[2:0]), cur_set)
      `CHK("hiz", 8'h00, sw_on)
    end
    tick(5);
    `CHK("hold", exp_cur(3'h1), cur_set)
    $display("stepping done");
    init_n = 1'b0;
    step;
    step;
    `CHK("init", sss_pkg::CUR_INIT, cur_set)
    out_enable = 1'b1;
    tick(10);
    `CHK("drive", 1'b1, drive_active)
    `CHK("b_off", 4'h0, sw_on[7:4])
    `CHK("a_on", 1'b1, |sw_on[3:0])
    init_n = 1'b1;
    tick(1);
    step;
    `CHK("run", exp_cur(3'h1), cur_set)
    `CHK("b_on", 1'b1, |sw_on[7:4])
    $display("drive done");
    for (int i = 0; i < 8; i++) begin
      trip = 8'h01 << i;
      tick(2);
      `CHK("alert", 1'b0, fault_n)
      `CHK("off", 8'h00, sw_on)
      trip = 8'h00;
      out_enable = 1'b0;
      tick(1);
      `CHK("clear", 1'b1, fault_n)
      out_enable = 1'b1;
      tick(10);
    end
    $display("fault done");
    out_enable = 1'b0;
    tick(1);
    `CHK("idle", 8'h00, sw_on)
    test_done;
  end
endmodule
